// [shared/nsh_regs.vh]
`ifndef NSH_REGS_VH
`define NSH_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define NSH_ADDR_CTRL 8'h00
`define NSH_ADDR_PWRUP 8'h04
`define NSH_ADDR_HBEAT 8'h08
`define NSH_ADDR_STATE 8'h0c
`define NSH_ADDR_INTST 8'h10
`define NSH_ADDR_INTMSK 8'h14
`define NSH_ADDR_NODEID 8'h18

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define NSH_CTRL_APPSTART 0
`define NSH_CTRL_APPCFG 1
`define NSH_CTRL_NETCFG 2
`define NSH_CTRL_RESET 3'h0

// ----------------------------------------------------------------------
// Power-up delay, tenths of a second
// ----------------------------------------------------------------------
`define NSH_PWRUP_MAX 10'h258
`define NSH_PWRUP_RESET 10'h000
`define NSH_MS_PER_TENTH 7'h64

// ----------------------------------------------------------------------
// Heartbeat interval fields and clamp
// ----------------------------------------------------------------------
`define NSH_HB_MS 9:0
`define NSH_HB_SEC 15:10
`define NSH_HB_MIN 21:16
`define NSH_HB_HOUR 26:22
`define NSH_HB_DAY 31:27
`define NSH_HB_RESET 32'h00000000
`define NSH_MS_PER_SEC 32'h000003e8
`define NSH_MS_PER_MIN 32'h0000ea60
`define NSH_MS_PER_HOUR 32'h0036ee80
`define NSH_MS_PER_DAY 32'h05265c00
`define NSH_HB_CLAMP_MS 32'h0293_2e00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define NSH_CLK_HZ 25000000
`define NSH_MS_PER_S 1000
`define NSH_BLINK_HALF_MS 10'h1f4
`define NSH_FIRST_LIMIT_MS 16'h0bb8

// ----------------------------------------------------------------------
// Interrupt bits
// ----------------------------------------------------------------------
`define NSH_INT_SENT 0
`define NSH_INT_REQ 1
`define NSH_INT_FAIL 2
`define NSH_INT_WIDTH 3

`endif

// [src/nsh_node_status.v]
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "nsh_regs.vh"
//
// Contract
// RULE1 - Power indicator is lit whenever the node is supplied.
// RULE2 - Run indicator lights only after self-test done and application started.
// RULE3 - Once running, a failed outgoing variable update lights the error indicator.
// RULE4 - A successful outgoing variable update turns the error indicator off.
// RULE5 - Reserved indicator stays off always.
// RULE6 - Service steady on if application unconfigured, blinking if network unconfigured.
// RULE7 - An object request makes the node send its status variable.
// RULE8 - With zero power-up delay the first status goes out within three seconds.
// RULE9 - Random part of first delay comes from the unique node identifier.
// RULE10 - Power-up delay accepts 0 to 60 s in 0.1 s steps.
// RULE11 - First status is sent at power-up delay plus random offset.
// RULE12 - Configurer raises power-up delay if receivers are not ready yet.
// RULE13 - After the first status, status is resent every heartbeat interval.
// RULE14 - Heartbeat interval of zero suppresses all periodic sends.
// RULE15 - Heartbeat interval is days, hours, minutes, seconds and milliseconds.
// RULE16 - Intervals above twelve hours are used as exactly twelve hours.
// RULE17 - Heartbeat interval restarts at every status transmission.
// RULE18 - Service blink has fixed period with equal on and off times.
module nsh_node_status #(
    parameter CLK_PER_MS = 25000,
    parameter [15:0] NODE_ID = 16'h5a3c
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Node application events
    input wire selfTestDone,
    input wire objectRequestInput,
    input wire updateDone,
    input wire updateFailed,
    // Network side
    output reg objectStatusOutput,
    // Front-panel indicators
    output reg powerIndicator,
    output reg runIndicator,
    output reg errorIndicator,
    output reg reservedIndicator,
    output reg serviceIndicator,
    // Interrupt
    output reg irq
);

    // ------------------------------------------------------------------
    // Millisecond tick
    // ------------------------------------------------------------------
    reg [31:0] divCnt_q;
    reg msTick_q;

    always @(posedge clk) begin
        if (reset) begin
            divCnt_q <= 32'h0;
            msTick_q <= 1'b0;
        end else if (divCnt_q >= CLK_PER_MS - 1) begin
            divCnt_q <= 32'h0;
            msTick_q <= 1'b1;
        end else begin
            divCnt_q <= divCnt_q + 32'h1;
            msTick_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    reg [2:0] ctrl_q;
    reg [9:0] pwrupDelay_q;
    reg [31:0] hbSetting_q;
    reg [2:0] intStatus_q;
    reg [2:0] intMask_q;
    reg errFlag_q;
    reg firstSent_q;
    reg blink_q;
    reg [2:0] intEvent;

    wire setupPhase = psel & ~penable;
    wire accessDone = psel & penable & pready;
    wire wrDone = accessDone & pwrite & ~pslverr;
    wire appRunning = selfTestDone & ctrl_q[`NSH_CTRL_APPSTART];

    reg mapped;
    reg [31:0] rdValue;

    always @* begin
        mapped = 1'b1;
        rdValue = 32'h0;
        case (paddr)
            `NSH_ADDR_CTRL: begin
                rdValue = {29'h0, ctrl_q};
            end
            `NSH_ADDR_PWRUP: begin
                rdValue = {22'h0, pwrupDelay_q};
            end
            `NSH_ADDR_HBEAT: begin
                rdValue = hbSetting_q;
            end
            `NSH_ADDR_STATE: begin
                rdValue = {25'h0, firstSent_q, serviceIndicator, reservedIndicator,
                    errorIndicator, runIndicator, powerIndicator};
            end
            `NSH_ADDR_INTST: begin
                rdValue = {29'h0, intStatus_q};
            end
            `NSH_ADDR_INTMSK: begin
                rdValue = {29'h0, intMask_q};
            end
            `NSH_ADDR_NODEID: begin
                rdValue = {16'h0, NODE_ID};
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Zero-wait slave: the answer is registered in the setup cycle so that
    // every bus output comes straight from a flip-flop.
    always @(posedge clk) begin
        if (reset) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (setupPhase) begin
            prdata <= pwrite ? 32'h0 : rdValue;
            pready <= 1'b1;
            pslverr <= ~mapped;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            ctrl_q <= `NSH_CTRL_RESET;
            pwrupDelay_q <= `NSH_PWRUP_RESET;
            hbSetting_q <= `NSH_HB_RESET;
            intMask_q <= 3'h0;
        end else if (wrDone) begin
            case (paddr)
                `NSH_ADDR_CTRL: begin
                    ctrl_q <= pwdata[2:0];
                end
                `NSH_ADDR_PWRUP: begin
                    // Out-of-range writes are the configurer's fault; saturate
                    // rather than wrap so the delay never becomes short.
                    if (pwdata > {22'h0, `NSH_PWRUP_MAX}) begin
                        pwrupDelay_q <= `NSH_PWRUP_MAX; // RULE10
                    end else begin
                        pwrupDelay_q <= pwdata[9:0];
                    end
                end
                `NSH_ADDR_HBEAT: begin
                    hbSetting_q <= pwdata;
                end
                `NSH_ADDR_INTMSK: begin
                    intMask_q <= pwdata[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // First status scheduling
    // ------------------------------------------------------------------
    // Offset folded from the node identifier stays below 2048 ms, keeping
    // the zero-delay send inside the three-second limit.
    wire [10:0] randomOffset = NODE_ID[10:0] ^ {6'h0, NODE_ID[15:11]}; // RULE9
    wire [15:0] firstTarget = pwrupDelay_q * `NSH_MS_PER_TENTH
        + {5'h0, randomOffset}; // RULE11 RULE8
    reg [15:0] upTime_q;

    always @(posedge clk) begin
        if (reset) begin
            upTime_q <= 16'h0;
        end else if (msTick_q && !firstSent_q) begin
            upTime_q <= upTime_q + 16'h1;
        end
    end

    wire firstDue = ~firstSent_q & (upTime_q >= firstTarget);

    // ------------------------------------------------------------------
    // Heartbeat interval
    // ------------------------------------------------------------------
    wire [31:0] hbRawMs = {22'h0, hbSetting_q[`NSH_HB_MS]}
        + {26'h0, hbSetting_q[`NSH_HB_SEC]} * `NSH_MS_PER_SEC
        + {26'h0, hbSetting_q[`NSH_HB_MIN]} * `NSH_MS_PER_MIN
        + {27'h0, hbSetting_q[`NSH_HB_HOUR]} * `NSH_MS_PER_HOUR
        + {27'h0, hbSetting_q[`NSH_HB_DAY]} * `NSH_MS_PER_DAY; // RULE15
    // Day counts up to 31 keep the raw sum below 2^32, so no overflow.
    wire [31:0] hbMs = (hbRawMs > `NSH_HB_CLAMP_MS) ?
        `NSH_HB_CLAMP_MS : hbRawMs; // RULE16
    wire hbEnabled = (hbRawMs != 32'h0); // RULE14
    reg [31:0] hbCnt_q;

    wire hbDue = firstSent_q & hbEnabled & (hbCnt_q >= hbMs); // RULE13
    wire sendNow = firstDue | hbDue | objectRequestInput; // RULE7

    always @(posedge clk) begin
        if (reset) begin
            hbCnt_q <= 32'h0;
        end else if (sendNow) begin
            hbCnt_q <= 32'h0; // RULE17
        end else if (msTick_q && hbEnabled) begin
            hbCnt_q <= hbCnt_q + 32'h1;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            firstSent_q <= 1'b0;
            objectStatusOutput <= 1'b0;
        end else begin
            objectStatusOutput <= sendNow;
            if (sendNow) begin
                firstSent_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Service blink
    // ------------------------------------------------------------------
    reg [9:0] blinkCnt_q;

    always @(posedge clk) begin
        if (reset) begin
            blinkCnt_q <= 10'h0;
            blink_q <= 1'b0;
        end else if (msTick_q) begin
            if (blinkCnt_q >= `NSH_BLINK_HALF_MS - 10'h1) begin
                blinkCnt_q <= 10'h0;
                blink_q <= ~blink_q; // RULE18
            end else begin
                blinkCnt_q <= blinkCnt_q + 10'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Error flag
    // ------------------------------------------------------------------
    // A failure while the application runs wins over a success in the same
    // cycle, so a fault is never hidden by a coincident good update.
    always @(posedge clk) begin
        if (reset) begin
            errFlag_q <= 1'b0;
        end else if (appRunning && updateFailed) begin
            errFlag_q <= 1'b1; // RULE3
        end else if (updateDone) begin
            errFlag_q <= 1'b0; // RULE4
        end
    end

    // ------------------------------------------------------------------
    // Indicators
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            powerIndicator <= 1'b1;
            runIndicator <= 1'b0;
            errorIndicator <= 1'b0;
            reservedIndicator <= 1'b0;
            serviceIndicator <= 1'b0;
        end else begin
            powerIndicator <= 1'b1; // RULE1
            runIndicator <= appRunning; // RULE2
            errorIndicator <= errFlag_q;
            reservedIndicator <= 1'b0; // RULE5
            if (!ctrl_q[`NSH_CTRL_APPCFG]) begin
                serviceIndicator <= 1'b1; // RULE6
            end else if (!ctrl_q[`NSH_CTRL_NETCFG]) begin
                serviceIndicator <= blink_q; // RULE6
            end else begin
                serviceIndicator <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    always @* begin
        intEvent = 3'h0;
        intEvent[`NSH_INT_SENT] = sendNow;
        intEvent[`NSH_INT_REQ] = objectRequestInput;
        intEvent[`NSH_INT_FAIL] = appRunning & updateFailed;
    end

    wire intClrHit = wrDone & (paddr == `NSH_ADDR_INTST);
    wire [2:0] intClear = intClrHit ? pwdata[2:0] : 3'h0;

    // A new event in the clearing cycle survives the clear.
    always @(posedge clk) begin
        if (reset) begin
            intStatus_q <= 3'h0;
            irq <= 1'b0;
        end else begin
            intStatus_q <= (intStatus_q & ~intClear) | intEvent;
            irq <= |(((intStatus_q & ~intClear) | intEvent) & intMask_q);
        end
    end

endmodule

// [tb/nsh_checker.sv]
`timescale 1ns/1ps
// --------------------------------------------------------------
// Port checks of the node status block.
// --------------------------------------------------------------
module nsh_checker (
    input wire clk, reset,
    input wire psel, penable, pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata, prdata,
    input wire pready, pslverr,
    input wire selfTestDone, objectRequestInput, updateDone, updateFailed,
    input wire objectStatusOutput, powerIndicator, runIndicator,
    input wire errorIndicator, reservedIndicator, serviceIndicator, irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    AST_PWR_ON: assert property (powerIndicator)
        else $error("power indicator dark");
    AST_RES_OFF: assert property (!reservedIndicator)
        else $error("reserved indicator lit");
    AST_RUN_CAUSE: assert property (runIndicator |-> $past(selfTestDone))
        else $error("run lit before self test");
    AST_REQ_ANSWER: assert property (objectRequestInput |=> objectStatusOutput)
        else $error("request not answered");
    AST_ERR_SET: assert property (updateFailed && runIndicator ##1 !updateDone
        |=> errorIndicator) else $error("error not lit");
    AST_ERR_CLR: assert property (updateDone && !updateFailed ##1 !updateFailed
        |=> !errorIndicator) else $error("error not cleared");
    // A timer send clears the interval, so two sends in a row need a request.
    AST_SPACING: assert property (objectStatusOutput && !$past(objectRequestInput)
        |-> !$past(objectStatusOutput)) else $error("sends too close");
    AST_ZERO_WAIT: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("bad ready timing");
    AST_UNMAPPED: assert property (psel && !penable && paddr > 8'h18
        |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    cover property (objectRequestInput ##1 objectStatusOutput);
    cover property (updateFailed ##2 errorIndicator);
    cover property ($rose(serviceIndicator));
    cover property (pslverr);
endmodule
bind nsh_node_status nsh_checker u_chk (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .selfTestDone(selfTestDone),
    .objectRequestInput(objectRequestInput), .updateDone(updateDone),
    .updateFailed(updateFailed), .objectStatusOutput(objectStatusOutput),
    .powerIndicator(powerIndicator), .runIndicator(runIndicator),
    .errorIndicator(errorIndicator), .reservedIndicator(reservedIndicator),
    .serviceIndicator(serviceIndicator), .irq(irq));

// [tb/nsh_net_peer.sv]
`timescale 1ns/1ps
// --------------------------------------------------------------
// Other node on the channel: issues requests, logs status sends.
// --------------------------------------------------------------
module nsh_net_peer (
    // Clock
    input wire clk,
    // Network side
    input wire objectStatusOutput,
    output reg objectRequestInput,
    output reg updateDone,
    output reg updateFailed
);
    integer cyc = 0;
    integer nSent = 0;
    integer lastCyc = 0;
    integer prevCyc = 0;
    initial begin
        objectRequestInput = 1'b0;
        updateDone = 1'b0;
        updateFailed = 1'b0;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (objectStatusOutput === 1'b1) begin
            nSent <= nSent + 1;
            prevCyc <= lastCyc;
            lastCyc <= cyc;
        end
    end
    // Kind 0 request, 1 update done, 2 update failed; one pulse held high for n clock cycles.
    task pulse(input integer kind, input integer n);
        begin
            if (kind == 0) objectRequestInput <= 1'b1;
            if (kind == 1) updateDone <= 1'b1;
            if (kind == 2) updateFailed <= 1'b1;
            repeat (n) @(posedge clk);
            objectRequestInput <= 1'b0;
            updateDone <= 1'b0;
            updateFailed <= 1'b0;
        end
    endtask
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    localparam integer CPM = 4;
    localparam [15:0] NID = 16'h5a3c;
    localparam integer OFS = NID[10:0] ^ NID[15:11];
    reg clk, reset, psel, penable, pwrite, selfTestDone;
    reg [7:0] paddr;
    reg [31:0] pwdata, q;
    wire [31:0] prdata;
    wire pready, pslverr, objectStatusOutput, irq, objectRequestInput, updateDone;
    wire updateFailed, powerIndicator, runIndicator, errorIndicator;
    wire reservedIndicator, serviceIndicator;
    reg slvErr;
    integer nErrors, samplesChecked, rel, n, t, tick;
    nsh_node_status #(.CLK_PER_MS(CPM), .NODE_ID(NID)) u_dut (.clk(clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .selfTestDone(selfTestDone),
        .objectRequestInput(objectRequestInput), .updateDone(updateDone),
        .updateFailed(updateFailed), .objectStatusOutput(objectStatusOutput),
        .powerIndicator(powerIndicator), .runIndicator(runIndicator),
        .errorIndicator(errorIndicator), .reservedIndicator(reservedIndicator),
        .serviceIndicator(serviceIndicator), .irq(irq));
    nsh_net_peer u_peer (.clk(clk), .objectStatusOutput(objectStatusOutput),
        .objectRequestInput(objectRequestInput), .updateDone(updateDone),
        .updateFailed(updateFailed));
    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    task endOfTest;
        begin
            $display("checks %0d mismatches %0d", samplesChecked, nErrors);
            if (nErrors == 0 && samplesChecked > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    task chk(input [8*8-1:0] nm, input [31:0] seen, input [31:0] exp);
        begin
            samplesChecked = samplesChecked + 1;
            if (seen !== exp) begin
                nErrors = nErrors + 1;
                $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // Values sampled after a wake-up at the edge are the pre-edge ones.
    task apb(input w, input [7:0] a, input [31:0] d);
        begin
            psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
            @(posedge clk) penable <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1) @(posedge clk);
            q = prdata;
            slvErr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            // One idle edge keeps two calls from driving psel twice in one step.
            @(posedge clk);
        end
    endtask
    task doReset;
        begin
            reset <= 1'b1;
            repeat (12) @(posedge clk);
            reset <= 1'b0;
            rel = u_peer.cyc;
            @(posedge clk);
        end
    endtask
    task waitSends(input integer k);
        begin
            n = u_peer.nSent;
            while (u_peer.nSent < n + k) @(posedge clk);
        end
    endtask
    // Time in cycles from one millisecond tick below to two ticks above the expected value.
    function bit near(input integer c, input integer e);
        near = (c >= e - CPM) && (c <= e + 2 * CPM);
    endfunction
    task hiTime(input v);
        begin
            while (serviceIndicator !== v) @(posedge clk);
            t = u_peer.cyc;
            while (serviceIndicator === v) @(posedge clk);
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial tick = 0;
    always @(posedge clk) begin
        tick <= tick + 1;
        if (tick == 60000) begin
            nErrors = nErrors + 1;
            endOfTest;
        end
    end
    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    initial begin
        reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; selfTestDone = 1'b0;
        nErrors = 0; samplesChecked = 0;
        doReset;
        chk("pwr", powerIndicator, 1);
        chk("res", reservedIndicator, 0);
        apb(0, 8'h00, 0); chk("ctrl", q, 0);
        apb(0, 8'h08, 0); chk("hbeat", q, 0);
        apb(0, 8'h18, 0); chk("nodeid", q, NID);
        apb(0, 8'h20, 0); chk("unmap", {slvErr, q[30:0]}, 32'h80000000);
        chk("svc", serviceIndicator, 1);
        waitSends(1); @(posedge clk);
        chk("first0", near(u_peer.lastCyc - rel, OFS * CPM), 1);
        $display("power-up send done");
        doReset;
        apb(1, 8'h04, 700); apb(0, 8'h04, 0); chk("sat", q, 600);
        apb(1, 8'h04, 2);
        waitSends(1); @(posedge clk);
        chk("first2", near(u_peer.lastCyc - rel, (OFS + 200) * CPM), 1);
        apb(1, 8'h08, 32'h405); waitSends(2); @(posedge clk);
        chk("hbgap", near(u_peer.lastCyc - u_peer.prevCyc, 1005 * CPM), 1);
        repeat (2000) @(posedge clk);
        u_peer.pulse(0, 1); waitSends(2); @(posedge clk);
        chk("restart", near(u_peer.lastCyc - u_peer.prevCyc, 1005 * CPM), 1);
        apb(1, 8'h08, 0); n = u_peer.nSent; repeat (5000) @(posedge clk);
        chk("nohb", u_peer.nSent, n);
        $display("heartbeat done");
        apb(1, 8'h10, 7); apb(1, 8'h14, 3); n = u_peer.nSent;
        u_peer.pulse(0, 2); repeat (2) @(posedge clk);
        chk("req2", u_peer.nSent, n + 2);
        chk("irq", irq, 1);
        apb(0, 8'h10, 0); chk("intst", q, 3);
        apb(1, 8'h10, 3); apb(0, 8'h10, 0); chk("w1c", q, 0);
        chk("irqclr", irq, 0);
        $display("request and interrupt done");
        u_peer.pulse(2, 1); repeat (3) @(posedge clk);
        chk("errpre", errorIndicator, 0);
        apb(1, 8'h00, 1); repeat (2) @(posedge clk);
        chk("runpre", runIndicator, 0);
        selfTestDone <= 1'b1; repeat (3) @(posedge clk);
        chk("run", runIndicator, 1);
        u_peer.pulse(2, 1); repeat (3) @(posedge clk);
        chk("erron", errorIndicator, 1);
        u_peer.pulse(1, 1); repeat (3) @(posedge clk);
        chk("erroff", errorIndicator, 0);
        chk("svcon", serviceIndicator, 1);
        apb(1, 8'h00, 3); hiTime(0); hiTime(1);
        chk("blinkhi", near(u_peer.cyc - t, 500 * CPM), 1);
        hiTime(0);
        chk("blinklo", near(u_peer.cyc - t, 500 * CPM), 1);
        apb(1, 8'h00, 7); repeat (2) @(posedge clk);
        chk("svcoff", serviceIndicator, 0);
        $display("indicators done");
        endOfTest;
    end
endmodule
